// ---- hdl/asrp_pkg.sv ----
// shared constants and types of the serial register port
// assumes a single mclk domain; pins arrive unsynchronised
`default_nettype none
package asrp_pkg;
    // ==========================================================
    // command byte fields
    localparam int CMD_RDY_BIT = 7;
    localparam int CMD_RS_LSB = 4;
    localparam int CMD_RW_BIT = 3;
    localparam int CMD_STBY_BIT = 2;
    localparam int CMD_GAIN_LSB = 0;
    // ==========================================================
    // register select codes
    localparam logic [1:0] REG_COMM = 2'h0;
    localparam logic [1:0] REG_SETUP = 2'h1;
    localparam logic [1:0] REG_TEST = 2'h2;
    localparam logic [1:0] REG_DATA = 2'h3;
    // ==========================================================
    // shift lengths as last bit index
    localparam logic [4:0] LAST_BYTE = 5'h07;
    localparam logic [4:0] LAST_WORD = 5'h0f;
    // ==========================================================
    // reset values
    localparam logic [6:0] COMM_RST = 7'h00;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [7:0] TEST_RST = 8'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;
    // ==========================================================
    // consecutive ones on the data input that resync the port
    localparam int RESYNC_ONES = 32;
    localparam int ONES_W = 6;
    // ==========================================================
    typedef enum logic [1:0] {
        ST_CMD,
        ST_WR,
        ST_RD
    } asrp_state_t;
endpackage : asrp_pkg
`default_nettype wire

// ---- hdl/asrp_port.sv ----
// serial register port of a sigma-delta converter, device side
// assumes sclk/cs_n/din are pins; sample_valid and update_warn come
// from the converter core on mclk
//
// Functional notes
// - 16-bit register: one 16-bit shift or two 8-bit shifts.
// - after eight command clocks, register write bits follow at once.
// - half duplex: no data driven on the output while writing.
// - data input is ignored while a read is set up.
// - read data leaves most significant bit first.
// - every transaction opens with a command write; reset awaits one.
// - ready falls on new result, rises on data read or update warning.
// - ready status is the MSB of the command register read.
// - 32 consecutive ones on data input resync the port; ones in a read phase are not counted.
`default_nettype none
module asrp_port
    import asrp_pkg::*;
#(
    parameter int RESYNC = RESYNC_ONES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe_n,
    output logic result_ready_n,
    input wire logic [15:0] sample_data,
    input wire logic sample_valid,
    input wire logic update_warn,
    output logic [7:0] setup_value,
    output logic [7:0] test_value,
    output logic [1:0] gain_sel,
    output logic standby
);
    // ==========================================================
    // state
    typedef struct packed {
        asrp_state_t st;
        logic [4:0] bits;
        logic len16;
        logic [1:0] rs;
        logic [15:0] shreg;
        logic [15:0] outsh;
        logic [ONES_W-1:0] ones;
        logic sclk_prev;
        logic [6:0] comm;
        logic [7:0] setup;
        logic [7:0] test;
        logic [15:0] data;
        logic rdy_n;
        logic dout;
        logic oe_n;
    } asrp_regs_t;

    localparam logic [ONES_W-1:0] ONES_LAST = ONES_W'(RESYNC - 1);

    asrp_regs_t r_reg;
    asrp_regs_t r_next;
    logic sclk_s;
    logic cs_n_s;
    logic din_s;
    logic rise;
    logic [7:0] cmd_byte;
    logic [4:0] last_bit;
    logic rd_done_data;

    // ==========================================================
    // pin synchronisers; sclk and cs_n idle high
    asrp_sync #(
        .W(3),
        .RST_VAL(3'h6)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d({sclk, cs_n, din}),
        .q({sclk_s, cs_n_s, din_s})
    );

    // host samples on rising edge, so do we
    assign rise = sclk_s & ~r_reg.sclk_prev & ~cs_n_s;
    // incoming bits enter at the bottom, msb first
    assign cmd_byte = {r_reg.shreg[6:0], din_s};
    // shift length follows the selected register width
    assign last_bit = r_reg.len16 ? LAST_WORD : LAST_BYTE;
    assign rd_done_data = rise && r_reg.st == ST_RD &&
        r_reg.bits == LAST_WORD && r_reg.rs == REG_DATA;

    // ==========================================================
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.sclk_prev = sclk_s;
        if (sample_valid) begin
            r_next.data = sample_data;
        end
        // ready rises on warning or finished data read
        if (update_warn || rd_done_data) begin
            r_next.rdy_n = 1'b1;
        end
        // a fresh result wins over a simultaneous clear
        if (sample_valid) begin
            r_next.rdy_n = 1'b0;
        end
        if (rise) begin
            unique case (r_reg.st)
                ST_CMD: begin
                    r_next.shreg = {r_reg.shreg[14:0], din_s};
                    r_next.bits = r_reg.bits + 5'h01;
                    if (r_reg.bits == LAST_BYTE) begin
                        r_next.bits = 5'h00;
                        // a set status bit marks the byte as no command
                        if (!cmd_byte[CMD_RDY_BIT]) begin
                            r_next.comm = cmd_byte[6:0];
                            r_next.rs = cmd_byte[CMD_RS_LSB +: 2];
                            r_next.len16 =
                                cmd_byte[CMD_RS_LSB +: 2] == REG_DATA;
                            if (cmd_byte[CMD_RW_BIT]) begin
                                r_next.st = ST_RD;
                                unique case (cmd_byte[CMD_RS_LSB +: 2])
                                    REG_COMM: r_next.outsh =
                                        {r_reg.rdy_n, cmd_byte[6:0], 8'h00};
                                    REG_SETUP: r_next.outsh =
                                        {r_reg.setup, 8'h00};
                                    REG_TEST: r_next.outsh =
                                        {r_reg.test, 8'h00};
                                    REG_DATA: r_next.outsh = r_reg.data;
                                endcase
                            end else begin
                                r_next.st = ST_WR;
                            end
                        end
                    end
                end
                ST_WR: begin
                    r_next.shreg = {r_reg.shreg[14:0], din_s};
                    r_next.bits = r_reg.bits + 5'h01;
                    if (r_reg.bits == last_bit) begin
                        r_next.bits = 5'h00;
                        r_next.st = ST_CMD;
                        // the data register is read only; writes drop
                        if (r_reg.rs == REG_SETUP) begin
                            r_next.setup = cmd_byte;
                        end
                        if (r_reg.rs == REG_TEST) begin
                            r_next.test = cmd_byte;
                        end
                    end
                end
                ST_RD: begin
                    // din not looked at; shift msb out
                    r_next.outsh = {r_reg.outsh[14:0], 1'b0};
                    r_next.bits = r_reg.bits + 5'h01;
                    if (r_reg.bits == last_bit) begin
                        r_next.bits = 5'h00;
                        r_next.st = ST_CMD;
                    end
                end
            endcase
            // run of ones returns the port to command state
            if (r_reg.st != ST_RD) begin
                r_next.ones = din_s ? r_reg.ones + 1'b1 : '0;
                if (din_s && r_reg.ones == ONES_LAST) begin
                    r_next.ones = '0;
                    r_next.st = ST_CMD;
                    r_next.bits = 5'h00;
                end
            end else begin
                r_next.ones = '0;
            end
        end
        // msb presented as soon as the read phase opens
        r_next.dout = r_next.outsh[15];
        // drive only in a selected read phase
        r_next.oe_n = !(r_next.st == ST_RD && !cs_n_s);
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.st <= ST_CMD;
            r_reg.sclk_prev <= 1'b1;
            r_reg.comm <= COMM_RST;
            r_reg.setup <= SETUP_RST;
            r_reg.test <= TEST_RST;
            r_reg.data <= DATA_RST;
            r_reg.rdy_n <= 1'b1;
            r_reg.oe_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign dout = r_reg.dout;
    assign dout_oe_n = r_reg.oe_n;
    assign result_ready_n = r_reg.rdy_n;
    assign setup_value = r_reg.setup;
    assign test_value = r_reg.test;
    assign gain_sel = r_reg.comm[CMD_GAIN_LSB +: 2];
    assign standby = r_reg.comm[CMD_STBY_BIT];

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    half_duplex_a: assert property (
        r_reg.st != ST_RD |-> dout_oe_n)
        else $error("output driven outside read");
    read_ignores_din_a: assert property (
        rise && r_reg.st == ST_RD |=> $stable(r_reg.shreg) &&
        r_reg.ones == '0)
        else $error("din captured during read");
    cmd_to_write_a: assert property (
        rise && r_reg.st == ST_CMD && r_reg.bits == LAST_BYTE &&
        !cmd_byte[CMD_RDY_BIT] && !cmd_byte[CMD_RW_BIT] &&
        !(din_s && r_reg.ones == ONES_LAST)
        |=> r_reg.st == ST_WR && r_reg.bits == 5'h00)
        else $error("write phase not entered after command");
    msb_first_a: assert property (
        rise && r_reg.st == ST_RD |=> dout == $past(r_reg.outsh[14]))
        else $error("read bit order wrong");
    ready_set_a: assert property (
        sample_valid |=> !result_ready_n)
        else $error("ready not low after new result");
    ready_clear_a: assert property (
        rd_done_data && !sample_valid |=> result_ready_n ##1
        (result_ready_n || $past(sample_valid)))
        else $error("ready not high after data read");
    status_msb_a: assert property (
        rise && r_reg.st == ST_CMD && r_reg.bits == LAST_BYTE &&
        !cmd_byte[CMD_RDY_BIT] && cmd_byte[CMD_RW_BIT] &&
        cmd_byte[CMD_RS_LSB +: 2] == REG_COMM
        |=> r_reg.outsh[15] == $past(r_reg.rdy_n) && r_reg.st == ST_RD)
        else $error("status not in command msb");
    resync_a: assert property (
        rise && r_reg.st != ST_RD && din_s && r_reg.ones == ONES_LAST
        |=> r_reg.st == ST_CMD && r_reg.bits == 5'h00)
        else $error("ones run did not resync");
    byte_read_len_a: assert property (
        rise && r_reg.st == ST_RD && r_reg.bits == LAST_BYTE &&
        !r_reg.len16 |=> r_reg.st == ST_CMD)
        else $error("byte read length wrong");
    reset_cmd_a: assert property (
        $past(rst) |-> r_reg.st == ST_CMD && r_reg.bits == 5'h00)
        else $error("not awaiting command after reset");

    setup_write_c: cover property (
        r_reg.st == ST_WR && r_reg.rs == REG_SETUP ##1 r_reg.st == ST_CMD);
    data_read_c: cover property (rd_done_data);
    status_read_c: cover property (
        r_reg.st == ST_RD && r_reg.rs == REG_COMM);
    resync_c: cover property (
        rise && din_s && r_reg.ones == ONES_LAST);
endmodule : asrp_port
`default_nettype wire

// ---- hdl/asrp_sync.sv ----
// two-stage synchroniser for a group of pin inputs
// assumes inputs may change at any time relative to mclk
`default_nettype none
module asrp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } asrp_sync_t;

    asrp_sync_t sync_reg;
    asrp_sync_t sync_next;

    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = d;
        sync_next.s2 = sync_reg.s1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_reg <= {RST_VAL, RST_VAL};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign q = sync_reg.s2;
endmodule : asrp_sync
`default_nettype wire

// ---- tb/adc_serial_register_port_test.sv ----
// self-checking bench for the serial register port
// assumes asrp_port under hdl/ and the host model asrp_host
`default_nettype none
module adc_serial_register_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    // shortened resync count keeps the run brief
    localparam int RESYNC_T = 12;
    logic mclk, rst, sclk, cs_n, din, dout, dout_oe_n, result_ready_n;
    logic sample_valid, update_warn, standby;
    logic [15:0] sample_data;
    logic [15:0] rv;
    logic [7:0] setup_value, test_value;
    logic [1:0] gain_sel;
    int n_fail = 0;
    int n_compared = 0;
    int oe_low = 0;
    // ==========================================================
    // design and host
    asrp_port #(.RESYNC(RESYNC_T)) dut (.mclk(mclk), .rst(rst),
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe_n(dout_oe_n), .result_ready_n(result_ready_n),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .update_warn(update_warn), .setup_value(setup_value),
        .test_value(test_value), .gain_sel(gain_sel), .standby(standby));
    asrp_host host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe_n(dout_oe_n));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // sampled mid-cycle, away from the edge that launches it
    always @(negedge mclk) begin
        if (dout_oe_n === 1'b0) oe_low++;
    end
    // ==========================================================
    // checking and closing
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    task automatic wait_ready();
        int i;
        for (i = 0; i < 20 && result_ready_n !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
        end
        if (result_ready_n !== 1'b0) begin
            n_fail++;
            $display("FAIL ready wait expected 0 seen %b", result_ready_n);
            results();
        end
    endtask : wait_ready
    task automatic pulse(input logic [15:0] v, input logic warn);
        sample_data = v;
        sample_valid = ~warn;
        update_warn = warn;
        @(posedge mclk);
        #1;
        sample_valid = 1'b0;
        update_warn = 1'b0;
    endtask : pulse
    // ==========================================================
    // scenarios
    task automatic t_setup();
        oe_low = 0;
        host.shift(16, 16'h1068, rv);
        chk("setup", {8'h00, setup_value}, 16'h0068);
        chk("gain", {14'h0, gain_sel}, 16'h0000);
        chk("standby", {15'h0, standby}, 16'h0000);
        chk("oe on write", oe_low[15:0], 16'h0000);
        $display("test setup done");
    endtask : t_setup
    task automatic t_split();
        host.shift(8, 16'h0027, rv);
        host.shift(8, 16'h00a5, rv);
        chk("test reg", {8'h00, test_value}, 16'h00a5);
        chk("gain", {14'h0, gain_sel}, 16'h0003);
        chk("standby", {15'h0, standby}, 16'h0001);
        chk("oe on write", oe_low[15:0], 16'h0000);
        // data register writes are shifted and dropped
        host.shift(8, 16'h0030, rv);
        host.shift(16, 16'h1234, rv);
        // command and read in one unbroken frame
        host.shift(16, 16'h1800, rv);
        chk("setup read", {8'h00, rv[7:0]}, 16'h0068);
        host.shift(8, 16'h0028, rv);
        host.shift(8, 16'h0000, rv);
        chk("test read", rv, 16'h00a5);
        $display("test split write done");
    endtask : t_split
    task automatic t_read();
        logic [15:0] v;
        // wait and read repeated per sample
        for (int k = 0; k < 2; k++) begin
            v = k ? 16'h3c5a : 16'hc3a5;
            pulse(v, 1'b0);
            chk("ready low", {15'h0, result_ready_n}, 16'h0000);
            wait_ready();
            host.shift(8, 16'h0038, rv);
            if (k == 0) begin
                host.shift(8, 16'h00ff, rv);
                chk("data high", rv, {8'h00, v[15:8]});
                host.shift(8, 16'h00ff, rv);
                chk("data low", rv, {8'h00, v[7:0]});
            end else begin
                host.shift(16, 16'hffff, rv);
                chk("data word", rv, v);
            end
            chk("ready high", {15'h0, result_ready_n}, 16'h0001);
        end
        chk("setup kept", {8'h00, setup_value}, 16'h0068);
        $display("test data read done");
    endtask : t_read
    task automatic t_status();
        // three-wire: select stays low, status polled
        host.three_wire = 1'b1;
        pulse(16'h1234, 1'b0);
        host.shift(8, 16'h0008, rv);
        host.shift(8, 16'h0000, rv);
        chk("status ready", rv, 16'h0008);
        pulse(16'h0000, 1'b1);
        chk("ready warn", {15'h0, result_ready_n}, 16'h0001);
        host.shift(8, 16'h0008, rv);
        host.shift(8, 16'h0000, rv);
        chk("status busy", rv, 16'h0088);
        host.three_wire = 1'b0;
        host.frame(1'b0);
        host.hold();
        $display("test status read done");
    endtask : t_status
    task automatic t_dsp();
        // sclk period 340 ns, under 3 MHz
        host.half = 17;
        host.dsp = 1'b1;
        host.dsp_rx = 1'b0;
        pulse(16'h5a3c, 1'b0);
        wait_ready();
        host.shift(8, 16'h0038, rv);
        host.dsp_rx = 1'b1;
        host.shift(16, 16'h0000, rv);
        chk("dsp data", rv, 16'h5a3c);
        chk("dsp ready", {15'h0, result_ready_n}, 16'h0001);
        host.dsp = 1'b0;
        host.dsp_rx = 1'b0;
        host.half = 4;
        $display("test dsp frame done");
    endtask : t_dsp
    task automatic t_reset();
        pulse(16'h0f0f, 1'b0);
        host.shift(5, 16'h0002, rv);
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk("reset ready", {15'h0, result_ready_n}, 16'h0001);
        chk("reset setup", {8'h00, setup_value}, 16'h0000);
        host.shift(16, 16'h2081, rv);
        chk("test after reset", {8'h00, test_value}, 16'h0081);
        $display("test mid-run reset done");
    endtask : t_reset
    task automatic t_resync();
        host.shift(8, 16'h0010, rv);
        host.shift(3, 16'h0002, rv);
        host.shift(RESYNC_T, 16'hffff, rv);
        host.shift(16, 16'h205a, rv);
        chk("test reg", {8'h00, test_value}, 16'h005a);
        chk("setup", {8'h00, setup_value}, 16'h005f);
        $display("test resync done");
    endtask : t_resync
    // ==========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        sample_data = 16'h0000;
        sample_valid = 1'b0;
        update_warn = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        t_setup();
        t_split();
        t_read();
        t_status();
        t_dsp();
        t_resync();
        t_reset();
        results();
    end
endmodule : adc_serial_register_port_test
`default_nettype wire

// ---- tb/asrp_host.sv ----
// host model driving the serial pins of the register port, mode 3
// assumes mclk at 100 MHz; one bit lasts 2*half mclk (80 ns by default)
`default_nettype none
module asrp_host (
    input wire logic mclk,
    output var logic sclk,
    output var logic cs_n,
    output var logic din,
    input wire logic dout,
    input wire logic dout_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // half a serial clock in mclk cycles; 4 gives the 80 ns bench period
    int half = 4;
    // three-wire use keeps chip select low between frames
    logic three_wire = 1'b0;
    // a DSP host frames with two active-low syncs; dsp_rx picks receive
    logic dsp = 1'b0;
    logic dsp_rx = 1'b0;
    logic receive_frame_sync_n = 1'b1;
    logic transmit_frame_sync_n = 1'b1;
    // ==========================================================
    // pins at rest
    // clock idles high
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    task automatic hold();
        repeat (half) @(posedge mclk);
        #1;
    endtask : hold
    // select active while either frame sync is
    task automatic frame(input logic on);
        receive_frame_sync_n = !(on && dsp && dsp_rx);
        transmit_frame_sync_n = !(on && dsp && !dsp_rx);
        if (dsp) begin
            cs_n = receive_frame_sync_n & transmit_frame_sync_n;
        end else begin
            cs_n = !(on || three_wire);
        end
    endtask : frame
    // ==========================================================
    // one frame of n bits; rv collects dout, unknown while released
    task automatic shift(input int n, input logic [15:0] wv,
                         output logic [15:0] rv);
        rv = '0;
        frame(1'b1);
        hold();
        for (int i = n - 1; i >= 0; i--) begin
            // data set at the falling edge, msb first
            sclk = 1'b0;
            din = wv[i];
            hold();
            rv = {rv[14:0], (dout_oe_n === 1'b0) ? dout : 1'bx};
            sclk = 1'b1;
            hold();
        end
        // a released line must not keep showing its last level
        frame(1'b0);
        din = ~din;
        hold();
    endtask : shift
endmodule : asrp_host
`default_nettype wire
